// ===== hw/sar_adc_pkg.sv
/*
 Shared constants, types and decode functions for the SAR converter sequencer.
 Assumes a 20 MHz oscillator clock and a 32-bit APB register bus.
*/
package sar_adc_pkg;

   // ********************
   // Register map
   // ********************
   localparam logic [7:0] OFS_CTRL0 = 8'h00;
   localparam logic [7:0] OFS_CTRL2 = 8'h04;
   localparam logic [7:0] OFS_RES_HIGH = 8'h08;
   localparam logic [7:0] OFS_RES_LOW = 8'h0C;
   localparam logic [7:0] OFS_FLAG = 8'h10;

   // ********************
   // Field positions
   // ********************
   localparam int CTRL0_ENABLE_BIT = 0;
   localparam int CTRL0_GO_BIT = 1;
   localparam int CTRL0_CHAN_LSB = 2;
   localparam int CTRL2_FMT_BIT = 7;
   localparam int CTRL2_ACQ_LSB = 3;
   localparam int CTRL2_CLK_LSB = 0;
   localparam int FLAG_DONE_BIT = 0;

   // ********************
   // Reset values and counts
   // ********************
   localparam logic [3:0] CHAN_RST = 4'h0;
   localparam logic [2:0] ACQ_RST = 3'h0;
   localparam logic [2:0] CLK_SEL_RST = 3'h0;
   localparam logic [4:0] INSTR_CLKS = 5'h04;
   localparam logic [4:0] CONV_TADS = 5'h0B;
   localparam logic [4:0] WAIT_TADS = 5'h02;
   localparam logic [9:0] SAR_MSB = 10'h200;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SAMPLE = 3'b001,
      ST_DELAY = 3'b010,
      ST_ACQ = 3'b011,
      ST_CONV = 3'b100,
      ST_WAIT = 3'b101
   } seq_state_t;

   typedef struct packed {
      logic fmt;
      logic [2:0] acq;
      logic [2:0] clk_sel;
   } ctrl2_t;

   // Acquisition code to bit periods
   function automatic logic [4:0] acq_periods(input logic [2:0] code);
      case (code)
         3'h1: acq_periods = 5'h02;
         3'h2: acq_periods = 5'h04;
         3'h3: acq_periods = 5'h06;
         3'h4: acq_periods = 5'h08;
         3'h5: acq_periods = 5'h0C;
         3'h6: acq_periods = 5'h10;
         3'h7: acq_periods = 5'h14;
         default: acq_periods = 5'h00;
      endcase
   endfunction : acq_periods

   // Clock select code to oscillator periods per bit period
   function automatic logic [6:0] tad_div(input logic [2:0] sel);
      case (sel)
         3'h0: tad_div = 7'h02;
         3'h4: tad_div = 7'h04;
         3'h1: tad_div = 7'h08;
         3'h5: tad_div = 7'h10;
         3'h2: tad_div = 7'h20;
         3'h6: tad_div = 7'h40;
         default: tad_div = 7'h02;
      endcase
   endfunction : tad_div

endpackage : sar_adc_pkg

// ===== hw/tad_divider.sv
/*
 Bit-period tick generator: oscillator divider or internal RC tick.
 Assumes rc_tick_i is a one-cycle pulse synchronous to clock_i.
*/
`timescale 1ns/10ps
module tad_divider
   import sar_adc_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic [2:0] sel_i,
   input wire logic rc_tick_i,
   input wire logic sleep_i,
   output logic tick_o
);

   logic [6:0] count;
   logic [2:0] sel_last;
   logic use_rc;

   assign use_rc = (sel_i[1:0] == 2'h3);

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         sel_last <= CLK_SEL_RST;
      end else begin
         sel_last <= sel_i;
      end
   end

   // ********************
   // Divider
   // ********************
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         count <= 7'h00;
         tick_o <= 1'b0;
      end else if (sel_i != sel_last) begin
         count <= 7'h00;
         tick_o <= 1'b0;
      end else if (use_rc) begin
         count <= 7'h00;
         tick_o <= rc_tick_i;
      end else if (sleep_i) begin
         tick_o <= 1'b0;
      end else if (count == tad_div(sel_i) - 7'h01) begin
         count <= 7'h00;
         tick_o <= 1'b1;
      end else begin
         count <= count + 7'h01;
         tick_o <= 1'b0;
      end
   end

endmodule : tad_divider

// ===== hw/sar_adc_sequencer.sv
/*
 Control sequencer of a 10-bit successive-approximation converter
 with an APB register slave.
 Assumes a comparator result on cmp_i, a sleep level and an internal
 RC tick, all synchronous to clock_i.
*/
// Chosen here: the address map and the APB slave port.
// Functional notes
// - Reset turns converter off, abandons conversion
// - Completion loads result, clears start, sets flag
// - Result pair is not reset
// - Programmed acquisition samples N periods, then converts
// - Manual mode stops sampling, converts after one instruction cycle
// - Acquisition field resets to manual
// - After conversion, sample selected channel again
// - No acquisition-ended status; start bit only
// - Conversion lasts eleven bit periods
// - Clock select sets bit period
// - Successive approximation, one bit per period
// - Sleep conversions only on RC clock
// - Manual start delayed one instruction cycle
// - Two bit periods before next acquisition
// - Clearing start aborts, result kept
// - After wait, acquisition restarts automatically
`timescale 1ns/10ps
module sar_adc_sequencer
   import sar_adc_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic cmp_i,
   input wire logic sleep_i,
   input wire logic rc_tick_i,
   output logic sample_o,
   output logic [9:0] dac_o,
   output logic [3:0] channel_o,
   output logic conversion_complete_flag_o
);

   // ********************
   // Declarations
   // ********************
   seq_state_t state;
   seq_state_t next_state;
   ctrl2_t ctrl2;
   logic enable;
   logic go;
   logic [3:0] channel;
   logic flag;
   logic [7:0] result_high_byte;
   logic [7:0] result_low_byte;
   logic [4:0] cnt;
   logic [9:0] code;
   logic [9:0] mask;
   logic [9:0] decided;
   logic tick;
   logic done;
   logic abort;
   logic access;
   logic wr_en;
   logic [31:0] rd_word;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   function automatic logic mapped(input logic [7:0] a);
      mapped = hit(a, OFS_CTRL0) | hit(a, OFS_CTRL2) | hit(a, OFS_RES_HIGH)
         | hit(a, OFS_RES_LOW) | hit(a, OFS_FLAG);
   endfunction : mapped

   // ********************
   // Bit-period tick
   // ********************
   tad_divider u_tad (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .sel_i(ctrl2.clk_sel),
      .rc_tick_i(rc_tick_i),
      .sleep_i(sleep_i),
      .tick_o(tick)
   );

   // ********************
   // APB slave
   // ********************
   assign access = psel_i & penable_i;
   assign wr_en = access & pready_o & pwrite_i & mapped(paddr_i);

   always_comb begin
      rd_word = 32'h0000_0000;
      case (paddr_i)
         OFS_CTRL0: begin
            rd_word[CTRL0_ENABLE_BIT] = enable;
            rd_word[CTRL0_GO_BIT] = go;
            rd_word[CTRL0_CHAN_LSB +: 4] = channel;
         end
         OFS_CTRL2: begin
            rd_word[CTRL2_FMT_BIT] = ctrl2.fmt;
            rd_word[CTRL2_ACQ_LSB +: 3] = ctrl2.acq;
            rd_word[CTRL2_CLK_LSB +: 3] = ctrl2.clk_sel;
         end
         OFS_RES_HIGH: rd_word[7:0] = result_high_byte;
         OFS_RES_LOW: rd_word[7:0] = result_low_byte;
         OFS_FLAG: rd_word[FLAG_DONE_BIT] = flag;
         default: rd_word = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= 32'h0000_0000;
      end else begin
         pready_o <= access & ~pready_o;
         pslverr_o <= access & ~pready_o & ~mapped(paddr_i);
         if (access & ~pready_o) begin
            prdata_o <= pwrite_i ? 32'h0000_0000 : rd_word;
         end
      end
   end

   // ********************
   // Control registers
   // ********************
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         enable <= 1'b0;
         go <= 1'b0;
         channel <= CHAN_RST;
      end else begin
         if (done) begin
            go <= 1'b0;
         end
         if (wr_en && hit(paddr_i, OFS_CTRL0)) begin
            enable <= pwdata_i[CTRL0_ENABLE_BIT];
            go <= pwdata_i[CTRL0_GO_BIT] & pwdata_i[CTRL0_ENABLE_BIT];
            channel <= pwdata_i[CTRL0_CHAN_LSB +: 4];
         end
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl2 <= '{fmt: 1'b0, acq: ACQ_RST, clk_sel: CLK_SEL_RST};
      end else if (wr_en && hit(paddr_i, OFS_CTRL2)) begin
         ctrl2.fmt <= pwdata_i[CTRL2_FMT_BIT];
         ctrl2.acq <= pwdata_i[CTRL2_ACQ_LSB +: 3];
         ctrl2.clk_sel <= pwdata_i[CTRL2_CLK_LSB +: 3];
      end
   end

   // Completion flag: hardware set wins over a software clear
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         flag <= 1'b0;
      end else if (done) begin
         flag <= 1'b1;
      end else if (wr_en && hit(paddr_i, OFS_FLAG)) begin
         flag <= pwdata_i[FLAG_DONE_BIT];
      end
   end

   // Result pair keeps its value through reset
   always_ff @(posedge clock_i) begin
      if (done) begin
         if (ctrl2.fmt) begin
            result_high_byte <= {6'h00, decided[9:8]};
            result_low_byte <= decided[7:0];
         end else begin
            result_high_byte <= decided[9:2];
            result_low_byte <= {decided[1:0], 6'h00};
         end
      end else if (wr_en && hit(paddr_i, OFS_RES_HIGH)) begin
         result_high_byte <= pwdata_i[7:0];
      end else if (wr_en && hit(paddr_i, OFS_RES_LOW)) begin
         result_low_byte <= pwdata_i[7:0];
      end
   end

   // ********************
   // Sequencer
   // ********************
   assign abort = ~go & ((state == ST_DELAY) | (state == ST_ACQ) | (state == ST_CONV));

   always_comb begin
      next_state = state;
      done = 1'b0;
      case (state)
         ST_IDLE: begin
            if (enable) next_state = ST_SAMPLE;
         end
         ST_SAMPLE: begin
            if (go) begin
               next_state = (ctrl2.acq == ACQ_RST) ? ST_DELAY : ST_ACQ;
            end
         end
         ST_DELAY: begin
            if (cnt == INSTR_CLKS - 5'h01) next_state = ST_CONV;
         end
         ST_ACQ: begin
            if (tick && cnt == acq_periods(ctrl2.acq) - 5'h01) begin
               next_state = ST_CONV;
            end
         end
         ST_CONV: begin
            if (tick && cnt == CONV_TADS - 5'h01) begin
               next_state = ST_WAIT;
               done = 1'b1;
            end
         end
         ST_WAIT: begin
            if (tick && cnt == WAIT_TADS - 5'h01) next_state = ST_SAMPLE;
         end
         default: next_state = ST_IDLE;
      endcase
      if (abort) begin
         next_state = ST_WAIT;
         done = 1'b0;
      end
      if (!enable) begin
         next_state = ST_IDLE;
         done = 1'b0;
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Shared counter: clocks in the delay, bit periods elsewhere
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         cnt <= 5'h00;
      end else if (next_state != state) begin
         cnt <= 5'h00;
      end else if (state == ST_DELAY || tick) begin
         cnt <= cnt + 5'h01;
      end
   end

   // ********************
   // Successive approximation
   // ********************
   assign decided = cmp_i ? code : (code & ~mask);

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         code <= 10'h000;
         mask <= 10'h000;
      end else if (state == ST_CONV && tick) begin
         if (cnt == 5'h00) begin
            code <= SAR_MSB;
            mask <= SAR_MSB;
         end else begin
            code <= decided | (mask >> 1);
            mask <= mask >> 1;
         end
      end
   end

   // ********************
   // Outputs
   // ********************
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         sample_o <= 1'b0;
         channel_o <= CHAN_RST;
         dac_o <= 10'h000;
         conversion_complete_flag_o <= 1'b0;
      end else begin
         sample_o <= (next_state == ST_SAMPLE) | (next_state == ST_ACQ);
         channel_o <= channel;
         dac_o <= code;
         conversion_complete_flag_o <= done | flag;
      end
   end

   // ********************
   // Assertions
   // ********************
   default clocking @(posedge clock_i);
   endclocking
   default disable iff (rst_i);

   sequence s_conv_end;
      state == ST_CONV && tick && cnt == 5'h0A && go && enable;
   endsequence

   sequence s_wait_end;
      state == ST_WAIT && tick && cnt == 5'h01 && enable && !abort;
   endsequence

   sequence s_manual_start;
      state == ST_SAMPLE && go && enable && ctrl2.acq == 3'h0;
   endsequence

   a_off_idle: assert property (!enable |=> state == ST_IDLE && !sample_o)
      else $error("converter not idle when off");

   a_done_effects: assert property (s_conv_end |=> !go && flag && state == ST_WAIT)
      else $error("completion effects missing");

   a_abort_keeps: assert property (abort && enable |=>
      $stable(result_high_byte) && $stable(result_low_byte) && state == ST_WAIT)
      else $error("abort changed result");

   a_manual_delay: assert property (s_manual_start |=> !sample_o && state == ST_DELAY
      ##1 (state == ST_DELAY || !go || !enable)[*3])
      else $error("manual start not delayed");

   a_acq_sample: assert property (state == ST_ACQ |-> sample_o &&
      cnt < acq_periods(ctrl2.acq))
      else $error("acquisition overrun");

   a_conv_len: assert property (state == ST_CONV |-> cnt <= 5'h0A && !sample_o)
      else $error("conversion too long");

   a_wait_len: assert property (state == ST_CONV ##1 state == ST_WAIT |->
      cnt == 5'h00 && !sample_o)
      else $error("wait not started fresh");

   a_resample: assert property (s_wait_end |=> state == ST_SAMPLE && sample_o)
      else $error("sampling not restarted");

   a_acq_field: assert property (ctrl2.acq == 3'h7 && state == ST_ACQ && tick &&
      cnt == 5'h13 && go && enable |=> state == ST_CONV)
      else $error("twenty period acquisition wrong");

endmodule : sar_adc_sequencer

// ===== sim/test_sar_adc_sequencer.sv
/*
 Self-checking bench for the SAR converter sequencer.
 Assumes the APB slave answers with pready_o and a comparator that follows ain.
*/
`timescale 1ns/10ps
module test_sar_adc_sequencer;
   import sar_adc_pkg::*;
   logic clock_i, rst_i, psel_i, penable_i, pwrite_i, cmp_i, sleep_i, rc_tick_i;
   logic [7:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, rd, hi_q, lo_q;
   logic pready_o, pslverr_o, sample_o, conversion_complete_flag_o, serr;
   logic [9:0] dac_o, ain;
   logic [3:0] channel_o;
   logic [2:0] rc_cnt;
   int errors, checks;
   int divs[6] = '{2, 4, 8, 16, 32, 64};
   logic [2:0] sels[6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
   int tads[8] = '{0, 2, 4, 6, 8, 12, 16, 20};

   sar_adc_sequencer sar_adc_sequencer_i (.clock_i(clock_i), .rst_i(rst_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .cmp_i(cmp_i),
      .sleep_i(sleep_i), .rc_tick_i(rc_tick_i), .sample_o(sample_o), .dac_o(dac_o),
      .channel_o(channel_o), .conversion_complete_flag_o(conversion_complete_flag_o));

   initial begin
      clock_i = 1'b0;
      forever #25 clock_i = ~clock_i;
   end

   // Comparator follows the trial code without a register stage
   assign cmp_i = (dac_o <= ain);

   // Internal RC tick, one pulse every 5 clocks
   always @(posedge clock_i) begin
      rc_cnt <= (rc_cnt == 3'h4) ? 3'h0 : rc_cnt + 3'h1;
      rc_tick_i <= (rc_cnt == 3'h4);
   end

   // ****************
   // Checks and bus
   // ****************
   task give_verdict;
      $display("Checks %0d, errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : give_verdict

   task check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check_val

   task check_range(input int got, input int lo, input int hi, input string what);
      checks++;
      if (got < lo || got > hi) begin
         errors++;
         $display("Error at %0t: %s took %0d, not in %0d..%0d", $time, what, got, lo, hi);
      end
   endtask : check_range

   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clock_i);
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clock_i);
      penable_i <= 1'b1;
      k = 0;
      do begin
         @(posedge clock_i);
         k++;
      end while (pready_o !== 1'b1 && k < 20);
      if (k >= 20) begin
         errors++;
         give_verdict;
      end
      rd = prdata_o;
      serr = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb

   task wait_for(input int sel, input int bound, output int c);
      c = 0;
      while (((sel == 0) ? conversion_complete_flag_o : sample_o) !== 1'b1 && c < bound) begin
         @(posedge clock_i);
         c++;
      end
      if (c >= bound) begin
         errors++;
         give_verdict;
      end
   endtask : wait_for

   task convert(input logic [2:0] sel, input logic [2:0] acq, input logic fmt,
                input logic [3:0] ch, input logic [9:0] v, input int div);
      int c;
      int pre;
      int n;
      n = tads[acq];
      pre = (acq == 3'h0) ? 4 : 0;
      ain <= v;
      apb(1'b1, OFS_CTRL2, {24'h0, fmt, 1'b0, acq, sel});
      apb(1'b1, OFS_FLAG, 32'h0000_0000);
      apb(1'b1, OFS_CTRL0, {26'h0, ch, 2'b01});
      repeat (48) @(posedge clock_i);
      apb(1'b1, OFS_CTRL0, {26'h0, ch, 2'b11});
      wait_for(0, 3000, c);
      check_range(c, pre + (n + 10) * div, pre + (n + 11) * div + 4, "conversion");
      check_val({31'h0, sample_o}, 32'h0000_0000, "sample after done");
      wait_for(1, 400, c);
      check_range(c, div - 1, 2 * div + 3, "resample");
      check_val({28'h0, channel_o}, {28'h0, ch}, "channel");
      apb(1'b0, OFS_CTRL0, 32'h0000_0000);
      check_val(rd, {26'h0, ch, 2'b01}, "go cleared");
      apb(1'b0, OFS_FLAG, 32'h0000_0000);
      check_val(rd, 32'h0000_0001, "flag set");
      apb(1'b0, OFS_RES_HIGH, 32'h0000_0000);
      hi_q = rd;
      check_val(rd, fmt ? {30'h0, v[9:8]} : {24'h0, v[9:2]}, "result high");
      apb(1'b0, OFS_RES_LOW, 32'h0000_0000);
      lo_q = rd;
      check_val(rd, fmt ? {24'h0, v[7:0]} : {24'h0, v[1:0], 6'h00}, "result low");
   endtask : convert

   // ****************
   // Scenarios
   // ****************
   task test_reset;
      check_val({sample_o, dac_o, channel_o, conversion_complete_flag_o}, 32'h0, "outs");
      apb(1'b0, OFS_CTRL0, 32'h0000_0000);
      check_val(rd, 32'h0000_0000, "ctrl0 reset");
      apb(1'b0, OFS_CTRL2, 32'h0000_0000);
      check_val(rd, 32'h0000_0000, "ctrl2 reset");
      apb(1'b0, 8'h20, 32'h0000_0000);
      check_val({31'h0, serr}, 32'h0000_0001, "unmapped error");
      $display("Done: reset values");
   endtask : test_reset

   task test_clocks;
      for (int i = 0; i < 6; i++) begin
         convert(sels[i], 3'h0, i[0], i[3:0], 10'h2A5 ^ i[9:0], divs[i]);
      end
      for (int a = 1; a < 8; a++) begin
         convert(3'h1, a[2:0], 1'b1, 4'hC, 10'h3FF - a[9:0], 8);
      end
      $display("Done: clock selects and acquisition codes");
   endtask : test_clocks

   task test_sleep;
      int c;
      apb(1'b1, OFS_FLAG, 32'h0000_0000);
      apb(1'b1, OFS_CTRL0, 32'h0000_0005);
      repeat (48) @(posedge clock_i);
      sleep_i <= 1'b1;
      apb(1'b1, OFS_CTRL2, 32'h0000_0080);
      apb(1'b1, OFS_CTRL0, 32'h0000_0007);
      repeat (200) @(posedge clock_i);
      check_val({31'h0, conversion_complete_flag_o}, 32'h0, "frozen in sleep");
      sleep_i <= 1'b0;
      wait_for(1, 400, c);
      check_range(c, 20, 34, "resume after sleep");
      sleep_i <= 1'b1;
      convert(3'h3, 3'h0, 1'b1, 4'h2, 10'h155, 5);
      convert(3'h7, 3'h2, 1'b0, 4'h9, 10'h0AA, 5);
      sleep_i <= 1'b0;
      $display("Done: sleep and RC clock");
   endtask : test_sleep

   task test_abort;
      int c;
      apb(1'b1, OFS_FLAG, 32'h0000_0000);
      apb(1'b1, OFS_CTRL2, 32'h0000_0006);
      apb(1'b1, OFS_CTRL0, 32'h0000_0015);
      repeat (48) @(posedge clock_i);
      apb(1'b1, OFS_CTRL0, 32'h0000_0017);
      repeat (100) @(posedge clock_i);
      apb(1'b1, OFS_CTRL0, 32'h0000_0015);
      wait_for(1, 400, c);
      check_range(c, 62, 136, "abort wait");
      repeat (900) @(posedge clock_i);
      apb(1'b0, OFS_FLAG, 32'h0000_0000);
      check_val(rd, 32'h0000_0000, "no flag on abort");
      apb(1'b0, OFS_RES_HIGH, 32'h0000_0000);
      check_val(rd, hi_q, "result kept");
      $display("Done: abort");
   endtask : test_abort

   task test_mid_reset;
      apb(1'b1, OFS_CTRL0, 32'h0000_0011);
      repeat (48) @(posedge clock_i);
      apb(1'b1, OFS_CTRL0, 32'h0000_0013);
      repeat (60) @(posedge clock_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clock_i);
      check_val({sample_o, dac_o, channel_o, conversion_complete_flag_o}, 32'h0, "outs");
      rst_i <= 1'b0;
      apb(1'b0, OFS_CTRL0, 32'h0000_0000);
      check_val(rd, 32'h0000_0000, "off after reset");
      apb(1'b0, OFS_RES_LOW, 32'h0000_0000);
      check_val(rd, lo_q, "result not reset");
      $display("Done: reset in conversion");
   endtask : test_mid_reset

   initial begin
      {rst_i, psel_i, penable_i, pwrite_i, sleep_i, rc_tick_i} = 6'b100000;
      {paddr_i, pwdata_i, ain, rc_cnt, errors, checks} = '0;
      repeat (20) @(posedge clock_i);
      rst_i <= 1'b0;
      test_reset;
      test_clocks;
      test_sleep;
      test_abort;
      test_mid_reset;
      give_verdict;
   end
endmodule : test_sar_adc_sequencer
